//--- hdl/epr_pkg.sv
// constants, encodings and carrier types of the ethernet port checker
// assumes one 40 MHz clock domain and an axi4-lite register slave
package epr_pkg;
  // timing
  localparam int MCLK_HZ = 40_000_000;
  localparam int ESMC_PERIOD_MS = 1000;
  localparam int ESMC_LOSS_MS = 5000;
  localparam int ESMC_PERIOD_CYC = MCLK_HZ / 1000 * ESMC_PERIOD_MS;
  localparam int ESMC_LOSS_CYC = MCLK_HZ / 1000 * ESMC_LOSS_MS;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PORT = 8'h04;
  localparam logic [7:0] REG_RXCFG = 8'h08;
  localparam logic [7:0] REG_JUMBO = 8'h0C;
  localparam logic [7:0] REG_MACLO = 8'h10;
  localparam logic [7:0] REG_MACHI = 8'h14;
  localparam logic [7:0] REG_IP = 8'h18;
  localparam logic [7:0] REG_VLAN = 8'h1C;
  localparam logic [7:0] REG_STAT = 8'h20;
  localparam logic [7:0] REG_PRECNT = 8'h24;
  localparam logic [7:0] REG_IFGCNT = 8'h28;
  localparam logic [7:0] REG_OVRCNT = 8'h2C;
  localparam logic [7:0] REG_QLSEL = 8'h30;
  localparam logic [7:0] REG_QLCNT = 8'h34;
  // control field positions
  localparam int C_ARP = 0;
  localparam int C_PING = 1;
  localparam int C_LF = 2;
  localparam int C_RUN = 3;
  localparam int C_IGNPRE = 4;
  localparam int C_IFGFLT = 5;
  localparam int C_ANRF = 6;
  localparam int C_INBAND = 7;
  localparam int C_SYNCE = 8;
  localparam int C_SYNCMODE = 9;
  localparam int C_VLAN = 10;
  localparam int C_EVT = 12;
  localparam int C_QL = 16;
  localparam int C_QLOPT = 20;
  // reset values, limits and fixed in-band header values
  localparam logic [3:0] PRE_DEF = 4'h8;
  localparam logic [3:0] PRE_MIN = 4'h3;
  localparam logic [3:0] IFG_DEF = 4'hC;
  localparam logic [3:0] IFG_MIN = 4'h8;
  localparam logic [13:0] JUMBO_DEF = 14'h233A;
  localparam logic [13:0] JUMBO_MIN = 14'h05EF;
  localparam logic [13:0] JUMBO_MAX = 14'h3E80;
  localparam logic [7:0] INB_TOS = 8'h00;
  localparam logic [7:0] INB_TTL = 8'h14;
  localparam logic [15:0] INB_TPID = 16'h8100;
  localparam logic [3:0] INB_PCP_DEI = 4'h0;
  typedef enum logic [2:0] {
    R10M = 3'h0, R100M = 3'h1, R1G = 3'h2, R10G = 3'h3, R25G = 3'h4, R40G = 3'h5, R100G = 3'h6
  } epr_rate_t;
  typedef enum logic [1:0] {IF_ELEC = 2'h0, IF_SFP = 2'h1, IF_OPT = 2'h2} epr_if_t;
  typedef enum logic [1:0] {OPT_I = 2'h0, OPT_II = 2'h1, OPT_III = 2'h2, OPT_PKT = 2'h3} epr_qlopt_t;
  typedef enum logic [1:0] {EV_DYN = 2'h0, EV_OFF = 2'h1, EV_ON = 2'h2} epr_evt_t;
  typedef enum logic [4:0] {
    QN_INV = 5'h00, QN_PRC = 5'h01, QN_SSUA = 5'h02, QN_SSUB = 5'h03, QN_SEC = 5'h04,
    QN_DNU = 5'h05, QN_EEC1 = 5'h06, QN_EEC2 = 5'h07, QN_UNK = 5'h08, QN_STU = 5'h09,
    QN_PRS = 5'h0A, QN_TNC = 5'h0B, QN_ST2 = 5'h0C, QN_ST3 = 5'h0D, QN_SMC = 5'h0E,
    QN_ST3E = 5'h0F, QN_PROV = 5'h10, QN_DUS = 5'h11
  } epr_qname_t;
  typedef struct packed {
    logic done;
    logic arpReq;
    logic [4:0] preLen;
    logic [7:0] ifgLen;
    logic [13:0] frmLen;
  } epr_rxfrm_t;
  typedef struct packed {logic valid; logic [3:0] ql;} epr_esmcrx_t;
  typedef struct packed {logic send; logic [3:0] ql; logic evtFlag;} epr_esmctx_t;
  typedef struct packed {logic sendRf; logic forceIdle; logic streamOn;} epr_txctl_t;
  typedef struct packed {
    logic vlanOn;
    logic [7:0] tos;
    logic [7:0] ttl;
    logic [15:0] tpid;
    logic [15:0] tci;
  } epr_inhdr_t;
endpackage

//--- hdl/epr_port_check.sv
// per-port receive checks, link fault response, in-band header and esmc engine
// assumes rx/link inputs come from pcs/parser logic on mclk; software via axi4-lite
`timescale 1ns/1ps
module epr_port_check #(
  parameter int PERIOD_CYC = epr_pkg::ESMC_PERIOD_CYC,
  parameter int LOSS_CYC = epr_pkg::ESMC_LOSS_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // receive side
  input wire epr_pkg::epr_rxfrm_t rxFrame,
  input wire epr_pkg::epr_esmcrx_t esmcRx,
  input wire logic rxLocalFault,
  input wire logic rxRemoteFault,
  input wire logic anPartnerRf,
  input wire logic otherPortInband,
  // transmit side
  output epr_pkg::epr_txctl_t txCtl,
  output logic arpReplySend,
  output logic [47:0] srcMac,
  output logic [31:0] srcIp,
  output epr_pkg::epr_inhdr_t inbandHdr,
  output epr_pkg::epr_esmctx_t esmcTx,
  output logic refLock,
  output logic syncAlarm
);
  import epr_pkg::*;

  typedef enum logic [2:0] {ST_OFF = 3'b001, ST_FIRST = 3'b010, ST_RUN = 3'b100} epr_txst_t;

  logic [31:0] ctrl_r;
  logic [2:0] rate_r;
  logic hiModule_r;
  logic [1:0] ifType_r;
  logic anMode_r;
  logic gigMode_r;
  logic [3:0] preExp_r;
  logic [3:0] ifgMin_r;
  logic [13:0] jumbo_r;
  logic [47:0] mac_r;
  logic [31:0] ip_r;
  logic [11:0] vid_r;
  logic [3:0] qlSel_r;
  logic [15:0] preCnt_r, ifgCnt_r, ovrCnt_r;
  logic [15:0] qlCnt_r [16];
  logic [3:0] lastQl_r;
  logic inbRefused_r;
  logic [7:0] awAddr_r;
  logic awHeld_r, wHeld_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic wrFire;
  logic [31:0] wrVal;
  logic [31:0] rdNxt;
  logic rdErr, wrErr;
  logic lfAllowed, lfEff, syncEAllowed, syncEEff, anRfActive;
  logic preViol, ifgViol, ovrViol;
  logic [27:0] perCnt_r, lossCnt_r;
  epr_txst_t txSt_r, txSt_nxt;
  epr_qname_t lastName;

  // byte-lane merge of a write onto the current value
  function automatic logic [31:0] mergeStrb(input logic [31:0] oldV, input logic [31:0] newV,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (oldV & ~m) | (newV & m);
  endfunction

  // quality code to name per selected option
  function automatic epr_qname_t qlDecode(input logic [1:0] opt, input logic [3:0] code);
    epr_qname_t n;
    n = QN_INV;
    case (opt)
      OPT_I: begin
        case (code)
          4'h2: n = QN_PRC;
          4'h4: n = QN_SSUA;
          4'h8: n = QN_SSUB;
          4'hB: n = QN_SEC;
          4'hF: n = QN_DNU;
          default: n = QN_INV;
        endcase
      end
      OPT_II: begin
        case (code)
          4'h0: n = QN_STU;
          4'h1: n = QN_PRS;
          4'h4: n = QN_TNC;
          4'h7: n = QN_ST2;
          4'hA: n = QN_ST3;
          4'hC: n = QN_SMC;
          4'hD: n = QN_ST3E;
          4'hE: n = QN_PROV;
          4'hF: n = QN_DUS;
          default: n = QN_INV;
        endcase
      end
      OPT_III: begin
        case (code)
          4'h0: n = QN_UNK;
          4'hB: n = QN_SEC;
          default: n = QN_INV;
        endcase
      end
      default: begin
        case (code)
          4'hA: n = QN_EEC2;
          4'hB: n = QN_EEC1;
          default: n = QN_INV;
        endcase
      end
    endcase
    return n;
  endfunction

  // qualified enables derived from port configuration
  assign lfAllowed = hiModule_r && (rate_r >= R10G);
  assign lfEff = ctrl_r[C_LF] && lfAllowed;
  assign syncEAllowed = (rate_r <= R25G);
  assign syncEEff = ctrl_r[C_SYNCE] && syncEAllowed;
  assign anRfActive = ctrl_r[C_ANRF] && anMode_r && (ifType_r == IF_ELEC || ifType_r == IF_SFP);
  assign lastName = qlDecode(ctrl_r[C_QLOPT +: 2], lastQl_r);

  // receive frame checks
  assign preViol = rxFrame.done && (rxFrame.preLen != {1'h0, preExp_r}) && !ctrl_r[C_IGNPRE];
  assign ifgViol = rxFrame.done && (rxFrame.ifgLen < {4'h0, ifgMin_r})
                   && !(ctrl_r[C_IFGFLT] && gigMode_r);
  assign ovrViol = rxFrame.done && (rxFrame.frmLen > jumbo_r);

  // axi handshake: address and data taken independently, response after both
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wrFire = awHeld_r && wHeld_r && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      awHeld_r <= 1'h0;
      wHeld_r <= 1'h0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'h1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'h1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_r <= 1'h0;
        wHeld_r <= 1'h0;
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= wrErr ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'h0;
      end
    end
  end

  // write decode: unmapped and read-only offsets answer slverr
  always_comb begin
    wrErr = 1'h0;
    wrVal = 32'h0;
    case (awAddr_r)
      REG_CTRL: wrVal = mergeStrb(ctrl_r, wData_r, wStrb_r);
      REG_PORT: wrVal = mergeStrb({23'h0, gigMode_r, anMode_r, ifType_r, hiModule_r, 1'h0, rate_r},
                                  wData_r, wStrb_r);
      REG_RXCFG: wrVal = mergeStrb({20'h0, ifgMin_r, 4'h0, preExp_r}, wData_r, wStrb_r);
      REG_JUMBO: wrVal = mergeStrb({18'h0, jumbo_r}, wData_r, wStrb_r);
      REG_MACLO: wrVal = mergeStrb(mac_r[31:0], wData_r, wStrb_r);
      REG_MACHI: wrVal = mergeStrb({16'h0, mac_r[47:32]}, wData_r, wStrb_r);
      REG_IP: wrVal = mergeStrb(ip_r, wData_r, wStrb_r);
      REG_VLAN: wrVal = mergeStrb({20'h0, vid_r}, wData_r, wStrb_r);
      REG_QLSEL: wrVal = mergeStrb({28'h0, qlSel_r}, wData_r, wStrb_r);
      REG_PRECNT, REG_IFGCNT, REG_OVRCNT, REG_QLCNT: wrVal = 32'h0; // write clears
      default: wrErr = 1'h1;
    endcase
  end

  // configuration; out-of-range limits keep their value
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_r <= 32'h0;
      rate_r <= R1G;
      hiModule_r <= 1'h0;
      ifType_r <= IF_ELEC;
      anMode_r <= 1'h0;
      gigMode_r <= 1'h0;
      preExp_r <= PRE_DEF;
      ifgMin_r <= IFG_DEF;
      jumbo_r <= JUMBO_DEF;
      mac_r <= 48'h0;
      ip_r <= 32'h0;
      vid_r <= 12'h000;
      qlSel_r <= 4'h0;
      inbRefused_r <= 1'h0;
    end else if (wrFire) begin
      case (awAddr_r)
        REG_CTRL: begin
          // a second port may not take in-band control
          ctrl_r <= wrVal;
          ctrl_r[C_INBAND] <= wrVal[C_INBAND] && !otherPortInband;
          inbRefused_r <= wrVal[C_INBAND] && otherPortInband;
        end
        REG_PORT: begin
          rate_r <= wrVal[2:0];
          hiModule_r <= wrVal[4];
          ifType_r <= wrVal[6:5];
          anMode_r <= wrVal[7];
          gigMode_r <= wrVal[8];
        end
        REG_RXCFG: begin
          if (wrVal[3:0] >= PRE_MIN) preExp_r <= wrVal[3:0];
          if (wrVal[11:8] >= IFG_MIN) ifgMin_r <= wrVal[11:8];
        end
        REG_JUMBO: begin
          if (wrVal[13:0] >= JUMBO_MIN && wrVal[13:0] <= JUMBO_MAX && wrVal[31:14] == 18'h0) begin
            jumbo_r <= wrVal[13:0];
          end
        end
        REG_MACLO: mac_r[31:0] <= wrVal;
        REG_MACHI: mac_r[47:32] <= wrVal[15:0];
        REG_IP: ip_r <= wrVal;
        REG_VLAN: vid_r <= wrVal[11:0];
        REG_QLSEL: qlSel_r <= wrVal[3:0];
        default: ;
      endcase
    end
  end

  // violation counters; an event in the clearing cycle still counts
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      preCnt_r <= 16'h0000;
      ifgCnt_r <= 16'h0000;
      ovrCnt_r <= 16'h0000;
    end else begin
      if (wrFire && awAddr_r == REG_PRECNT) preCnt_r <= {15'h0, preViol};
      else if (preViol && preCnt_r != 16'hFFFF) preCnt_r <= preCnt_r + 16'h1;
      if (wrFire && awAddr_r == REG_IFGCNT) ifgCnt_r <= {15'h0, ifgViol};
      else if (ifgViol && ifgCnt_r != 16'hFFFF) ifgCnt_r <= ifgCnt_r + 16'h1;
      if (wrFire && awAddr_r == REG_OVRCNT) ovrCnt_r <= {15'h0, ovrViol};
      else if (ovrViol && ovrCnt_r != 16'hFFFF) ovrCnt_r <= ovrCnt_r + 16'h1;
    end
  end

  // per-code esmc statistics, one saturating counter per quality code
  for (genvar i = 0; i < 16; i++) begin : g_qlcnt
    logic hit;
    assign hit = syncEEff && esmcRx.valid && (esmcRx.ql == 4'(i));
    always_ff @(posedge mclk) begin
      if (!rst_b) begin
        qlCnt_r[i] <= 16'h0000;
      end else if (wrFire && awAddr_r == REG_QLCNT) begin
        qlCnt_r[i] <= {15'h0, hit};
      end else if (hit && qlCnt_r[i] != 16'hFFFF) begin
        qlCnt_r[i] <= qlCnt_r[i] + 16'h1;
      end
    end
  end

  // read decode and data register
  always_comb begin
    rdErr = 1'h0;
    rdNxt = 32'h0;
    case (s_axi_araddr)
      REG_CTRL: rdNxt = ctrl_r;
      REG_PORT: rdNxt = {23'h0, gigMode_r, anMode_r, ifType_r, hiModule_r, 1'h0, rate_r};
      REG_RXCFG: rdNxt = {20'h0, ifgMin_r, 4'h0, preExp_r};
      REG_JUMBO: rdNxt = {18'h0, jumbo_r};
      REG_MACLO: rdNxt = mac_r[31:0];
      REG_MACHI: rdNxt = {16'h0, mac_r[47:32]};
      REG_IP: rdNxt = ip_r;
      REG_VLAN: rdNxt = {20'h0, vid_r};
      REG_STAT: rdNxt = {11'h0, lastName, lastQl_r, 1'h0, refLock, inbRefused_r,
                         ctrl_r[C_INBAND], anRfActive && anPartnerRf, anRfActive, syncAlarm,
                         syncEAllowed, lfAllowed, txCtl.streamOn, txCtl.forceIdle, txCtl.sendRf};
      REG_PRECNT: rdNxt = {16'h0, preCnt_r};
      REG_IFGCNT: rdNxt = {16'h0, ifgCnt_r};
      REG_OVRCNT: rdNxt = {16'h0, ovrCnt_r};
      REG_QLSEL: rdNxt = {28'h0, qlSel_r};
      REG_QLCNT: rdNxt = {16'h0, qlCnt_r[qlSel_r]};
      default: rdErr = 1'h1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'h1;
      s_axi_rdata <= rdNxt;
      s_axi_rresp <= rdErr ? 2'h2 : 2'h0;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'h0;
    end
  end

  // link fault response and address-resolution replies
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      txCtl <= '0;
      arpReplySend <= 1'h0;
      srcMac <= 48'h0;
      srcIp <= 32'h0;
    end else begin
      txCtl.sendRf <= lfEff && rxLocalFault;
      txCtl.forceIdle <= !ctrl_r[C_RUN] || (lfEff && rxRemoteFault);
      txCtl.streamOn <= ctrl_r[C_RUN] && !(lfEff && rxRemoteFault);
      arpReplySend <= rxFrame.done && rxFrame.arpReq
                      && (ctrl_r[C_ARP] || ctrl_r[C_PING]);
      srcMac <= mac_r;
      srcIp <= ip_r;
    end
  end

  // fixed in-band header fields; only the vlan enable and vlan id are software's
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      inbandHdr <= '0;
    end else begin
      inbandHdr.vlanOn <= ctrl_r[C_VLAN];
      inbandHdr.tos <= INB_TOS;
      inbandHdr.ttl <= INB_TTL;
      inbandHdr.tpid <= INB_TPID;
      inbandHdr.tci <= {INB_PCP_DEI, vid_r};
    end
  end

  // esmc receive: latest code and missing-message alarm
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lastQl_r <= 4'h0;
      lossCnt_r <= 28'h0;
      syncAlarm <= 1'h0;
    end else if (!syncEEff) begin
      lossCnt_r <= 28'h0;
      syncAlarm <= 1'h0;
    end else if (esmcRx.valid) begin
      lastQl_r <= esmcRx.ql;
      lossCnt_r <= 28'h0;
      syncAlarm <= 1'h0;
    end else if (lossCnt_r >= 28'(LOSS_CYC - 1)) begin
      syncAlarm <= 1'h1;
    end else begin
      lossCnt_r <= lossCnt_r + 28'h1;
    end
  end

  // esmc transmit: first message at once, then once per second
  always_comb begin
    txSt_nxt = txSt_r;
    case (txSt_r)
      ST_OFF: if (syncEEff && ctrl_r[C_SYNCMODE]) txSt_nxt = ST_FIRST;
      ST_FIRST: txSt_nxt = (syncEEff && ctrl_r[C_SYNCMODE]) ? ST_RUN : ST_OFF;
      ST_RUN: if (!(syncEEff && ctrl_r[C_SYNCMODE])) txSt_nxt = ST_OFF;
      default: txSt_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      txSt_r <= ST_OFF;
      perCnt_r <= 28'h0;
      esmcTx <= '0;
      refLock <= 1'h0;
    end else begin
      txSt_r <= txSt_nxt;
      refLock <= syncEEff && ctrl_r[C_SYNCMODE];
      esmcTx.send <= 1'h0;
      if (txSt_r == ST_FIRST && txSt_nxt == ST_RUN) begin
        perCnt_r <= 28'h0;
        esmcTx.send <= 1'h1;
        esmcTx.ql <= ctrl_r[C_QL +: 4];
        esmcTx.evtFlag <= (ctrl_r[C_EVT +: 2] != EV_OFF);
      end else if (txSt_r == ST_RUN && txSt_nxt == ST_RUN) begin
        if (perCnt_r >= 28'(PERIOD_CYC - 1)) begin
          perCnt_r <= 28'h0;
          esmcTx.send <= 1'h1;
          esmcTx.ql <= ctrl_r[C_QL +: 4];
          esmcTx.evtFlag <= (ctrl_r[C_EVT +: 2] == EV_ON);
        end else begin
          perCnt_r <= perCnt_r + 28'h1;
        end
      end else begin
        perCnt_r <= 28'h0;
      end
    end
  end
endmodule

//--- sim/epr_port_check_props.sv
// checker on the port checker's ports
// bound onto epr_port_check
`timescale 1ns/1ps
module epr_port_check_props #(
  parameter int PERIOD_CYC = 50,
  parameter int LOSS_CYC = 200
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // link side
  input wire epr_pkg::epr_rxfrm_t rxFrame,
  input wire epr_pkg::epr_esmcrx_t esmcRx,
  input wire logic rxLocalFault,
  input wire epr_pkg::epr_txctl_t txCtl,
  input wire logic arpReplySend,
  input wire epr_pkg::epr_inhdr_t inbandHdr,
  input wire epr_pkg::epr_esmctx_t esmcTx,
  input wire logic refLock,
  input wire logic syncAlarm
);
  import epr_pkg::*;
  int txGap_r, rxGap_r;
  logic txSeen_r;
  // cycles since last esmc send / receive
  always_ff @(posedge mclk) begin
    txGap_r <= (!rst_b || esmcTx.send) ? 0 : txGap_r + 1;
    rxGap_r <= (!rst_b || esmcRx.valid) ? 0 : rxGap_r + 1;
  end
  // a restart sends early: forget older sends
  always_ff @(posedge mclk) begin
    if (!rst_b || !refLock) txSeen_r <= 1'b0;
    else if (esmcTx.send) txSeen_r <= 1'b1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_rdWait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  sequence s_wrWait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_arp_reply_cause: assert property (arpReplySend |-> $past(rxFrame.done) && $past(rxFrame.arpReq))
    else $error("arp reply unasked");
  a_rf_needs_lf: assert property (txCtl.sendRf |-> $past(rxLocalFault))
    else $error("rf sent without lf");
  a_idle_or_stream: assert property (txCtl.streamOn |-> !txCtl.forceIdle)
    else $error("idle and streams at once");
  a_esmc_tx_period: assert property (esmcTx.send && txSeen_r |-> txGap_r == PERIOD_CYC - 1)
    else $error("esmc send spacing wrong");
  a_monitor_no_send: assert property (esmcTx.send |-> refLock)
    else $error("esmc sent in monitor mode");
  a_alarm_after_loss: assert property ($rose(syncAlarm) |-> rxGap_r >= LOSS_CYC - 2)
    else $error("sync alarm too early");
  a_inband_fixed_hdr: assert property ($past(rst_b, 2) |-> inbandHdr.tos == 8'h00 && inbandHdr.ttl == 8'h14
    && inbandHdr.tpid == 16'h8100 && inbandHdr.tci[15:12] == 4'h0)
    else $error("in-band header wrong");
  a_rdata_hold: assert property (s_rdWait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata dropped early");
  a_bresp_hold: assert property (s_wrWait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped early");
endmodule
bind epr_port_check epr_port_check_props #(.PERIOD_CYC(PERIOD_CYC), .LOSS_CYC(LOSS_CYC)) u_props (
  .mclk, .rst_b, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .rxFrame, .esmcRx, .rxLocalFault, .txCtl, .arpReplySend, .inbandHdr, .esmcTx, .refLock, .syncAlarm
);

//--- sim/epr_link_partner.sv
// link partner: frame summaries, esmc messages, fault levels
// tasks are entered just after a rising mclk edge
`timescale 1ns/1ps
module epr_link_partner (
  // clock
  input wire logic mclk,
  // toward the port's receive side
  output epr_pkg::epr_rxfrm_t rxFrame,
  output epr_pkg::epr_esmcrx_t esmcRx,
  output logic rxLocalFault,
  output logic rxRemoteFault,
  output logic anPartnerRf
);
  import epr_pkg::*;
  // quiet link at time zero
  initial begin
    rxFrame = '0;
    esmcRx = '0;
    {rxLocalFault, rxRemoteFault, anPartnerRf} = 3'h0;
  end
  // one-cycle summary, then flipped fields so stale data never match
  task automatic frame(input logic arp, input logic [4:0] pre, input logic [7:0] ifg, input logic [13:0] len);
    @(posedge mclk);
    rxFrame <= '{1'b1, arp, pre, ifg, len};
    @(posedge mclk);
    rxFrame <= '{1'b0, ~arp, ~pre, ~ifg, ~len};
  endtask
  // one esmc message
  task automatic esmc(input logic [3:0] ql);
    @(posedge mclk);
    esmcRx <= '{1'b1, ql};
    @(posedge mclk);
    esmcRx <= '{1'b0, ~ql};
  endtask
  // fault levels on the line
  task automatic faults(input logic lf, input logic rf, input logic an);
    rxLocalFault <= lf;
    rxRemoteFault <= rf;
    anPartnerRf <= an;
  endtask
endmodule

//--- sim/tb_epr_port_check.sv
// bench for epr_port_check: axi4-lite access and link stimulus
// assumes shortened esmc counts to keep the run short
`timescale 1ns/1ps
module tb_epr_port_check;
  import epr_pkg::*;
  localparam int PER = 50;
  localparam int LOSS = 200;
  logic mclk, rst_b, otherPortInband, awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady, arpReplySend, refLock, syncAlarm, got, lf, rf, anRf;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData, srcIp;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp;
  logic [47:0] srcMac;
  epr_rxfrm_t rxFrame;
  epr_esmcrx_t esmcRx;
  epr_txctl_t txCtl;
  epr_inhdr_t inb;
  epr_esmctx_t esmcTx;
  int failures, n_tests, cyc;
  // link fault rows: port, ctrl, {lf,rf}, expected txCtl, mask
  logic [23:0] lfTab [8] = '{24'h130C0F, 24'h130CA4, 24'h130C57, 24'h130C0F, 24'h130457, 24'h130417,
    24'h020CCF, 24'h030C84};
  logic [3:0] qCode [8] = '{4'h2, 4'h4, 4'h8, 4'hB, 4'hF, 4'h0, 4'hA, 4'hB};
  epr_qname_t qName [8] = '{QN_PRC, QN_SSUA, QN_SSUB, QN_SEC, QN_DNU, QN_INV, QN_EEC2, QN_EEC1};
  epr_port_check #(.PERIOD_CYC(PER), .LOSS_CYC(LOSS)) DUT (
    .mclk, .rst_b, .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .rxFrame, .esmcRx, .rxLocalFault(lf),
    .rxRemoteFault(rf), .anPartnerRf(anRf), .otherPortInband, .txCtl, .arpReplySend, .srcMac,
    .srcIp, .inbandHdr(inb), .esmcTx, .refLock, .syncAlarm);
  epr_link_partner u_link (.mclk, .rxFrame, .esmcRx, .rxLocalFault(lf), .rxRemoteFault(rf), .anPartnerRf(anRf));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // all compares; !== so an unknown never matches
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // write: aw and w offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er = 2'h0);
    awAddr <= a;
    wData <= dv;
    wStrb <= 4'hF;
    {awValid, wValid, bReady} <= 3'h7;
    forever begin
      @(posedge mclk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      if (bValid) break;
    end
    chk(32'(bResp), 32'(er));
    bReady <= 1'b0;
    @(posedge mclk);
  endtask
  // read and compare masked data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er = 2'h0);
    arAddr <= a;
    {arValid, rReady} <= 2'h3;
    forever begin
      @(posedge mclk);
      if (arReady) arValid <= 1'b0;
      if (rValid) break;
    end
    chk(rData & m, e);
    chk(32'(rResp), 32'(er));
    rReady <= 1'b0;
    @(posedge mclk);
  endtask
  // esmc send within n cycles, sampled mid-cycle
  task automatic waitSend(input int n);
    got = 1'b0;
    repeat (n) begin
      @(negedge mclk);
      if (esmcTx.send === 1'b1) begin
        got = 1'b1;
        break;
      end
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard, far above the run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_sim;
    end
  end
  initial begin
    {rst_b, otherPortInband, awValid, wValid, bReady, arValid, rReady, awAddr, arAddr, wData, wStrb} = '0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(REG_RXCFG, '1, 32'h0C08);
    rd(REG_JUMBO, '1, 32'h233A);
    rd(8'h40, '1, 32'h0, 2'h2);
    wr(REG_STAT, 32'h1, 2'h2);
    // rx checks at limits, then suppressed
    wr(REG_RXCFG, 32'h0803);
    wr(REG_JUMBO, 32'h05EF);
    for (int i = 0; i < 3; i++) wr(REG_PRECNT + 8'(4 * i), 32'h0);
    u_link.frame(1'b0, 5'h03, 8'h08, 14'h05EF);
    u_link.frame(1'b0, 5'h04, 8'h07, 14'h05F0);
    wr(REG_PORT, 32'h0102);
    wr(REG_CTRL, 32'h0030);
    u_link.frame(1'b0, 5'h09, 8'h07, 14'h0040);
    for (int i = 0; i < 3; i++) rd(REG_PRECNT + 8'(4 * i), 32'hFFFF, 32'h1);
    wr(REG_RXCFG, 32'h0702);
    rd(REG_RXCFG, 32'h0F0F, 32'h0803);
    wr(REG_JUMBO, 32'h3E81);
    rd(REG_JUMBO, 32'h3FFF, 32'h05EF);
    wr(REG_JUMBO, 32'h3E80);
    rd(REG_JUMBO, 32'h3FFF, 32'h3E80);
    // arp: off, answering, ping app
    wr(REG_MACLO, 32'h89ABCDEF);
    wr(REG_MACHI, 32'h4567);
    wr(REG_IP, 32'h0A000001);
    for (int i = 0; i < 3; i++) begin
      wr(REG_CTRL, 32'(i));
      u_link.frame(1'b1, 5'h08, 8'h0C, 14'h0040);
      @(negedge mclk);
      chk(32'(arpReplySend), 32'(i != 0));
      @(posedge mclk);
    end
    chk(srcMac[47:16], 32'h456789AB);
    chk(srcIp, 32'h0A000001);
    // in-band refused while another port holds it
    otherPortInband <= 1'b1;
    wr(REG_VLAN, 32'h0123);
    wr(REG_CTRL, 32'h0480);
    rd(REG_STAT, 32'h0300, 32'h0200);
    otherPortInband <= 1'b0;
    wr(REG_CTRL, 32'h0480);
    rd(REG_STAT, 32'h0300, 32'h0100);
    chk(32'({inb.vlanOn, inb.tos, inb.ttl}), 32'h10014);
    chk({inb.tpid, inb.tci}, 32'h81000123);
    // link fault response table
    for (int i = 0; i < 8; i++) begin
      wr(REG_PORT, {24'h0, lfTab[i][23:16]});
      wr(REG_CTRL, {24'h0, lfTab[i][15:8]});
      u_link.faults(lfTab[i][7], lfTab[i][6], 1'b0);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk(32'(txCtl & lfTab[i][2:0]), 32'(lfTab[i][5:3]));
      @(posedge mclk);
    end
    // autoneg rf: electrical counts, optical not
    u_link.faults(1'b0, 1'b0, 1'b1);
    wr(REG_CTRL, 32'h0040);
    wr(REG_PORT, 32'h0082);
    rd(REG_STAT, 32'h00C0, 32'h00C0);
    wr(REG_PORT, 32'h00C2);
    rd(REG_STAT, 32'h00C0, 32'h0);
    // quality codes, monitor mode
    for (int i = 0; i < 8; i++) begin
      wr(REG_CTRL, (i > 5) ? 32'h300100 : 32'h100);
      u_link.esmc(qCode[i]);
      rd(REG_STAT, 32'h1FF000, {11'h0, qName[i], qCode[i], 12'h0});
    end
    wr(REG_QLSEL, 32'hB);
    rd(REG_QLCNT, 32'hFFFF, 32'h2);
    repeat (LOSS + 10) @(posedge mclk);
    @(negedge mclk);
    chk(32'(syncAlarm), 32'h1);
    u_link.esmc(4'h2);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk(32'(syncAlarm), 32'h0);
    // sync mode sends; event flag dynamic, off, on
    wr(REG_PORT, 32'h0004);
    for (int j = 0; j < 3; j++) begin
      wr(REG_CTRL, 32'h0);
      wr(REG_CTRL, 32'h50300 | (32'(j) << 12));
      waitSend(20);
      chk(32'({got, esmcTx.ql, refLock}), 32'h2B);
      chk(32'(esmcTx.evtFlag), 32'(j != 1));
      waitSend(PER + 5);
      chk(32'({got, esmcTx.evtFlag}), 32'({1'b1, j == 2}));
      @(posedge mclk);
    end
    // monitor at 25G, sync at 40G: nothing sent
    for (int j = 0; j < 2; j++) begin
      wr(REG_PORT, j ? 32'h0005 : 32'h0004);
      wr(REG_CTRL, j ? 32'h50300 : 32'h50100);
      waitSend(PER + 5);
      chk(32'({got, refLock}), 32'h0);
      @(posedge mclk);
    end
    end_sim;
  end
endmodule
